// file: core/uart_single_wire.sv
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/10ps
// =====================================================================
module uart_single_wire
    import uart_sw_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       port_enable_i,
    input  wire logic       receiver_enable_i,
    input  wire logic       transmitter_enable_i,
    input  wire logic       receiver_interrupt_enable_i,
    output logic            receive_available_flag_o,
    output logic            interrupt_request_o,
    output logic            transmit_pin_o,
    output logic            transmit_pin_oe_o,
    input  wire logic       shared_serial_pin_i,
    output logic            shared_serial_pin_o,
    output logic            shared_serial_pin_oe_o
);
    // =================================================================
    // configuration registers
    logic        single_wire_select_r;
    logic [7:0]  div_high_r;
    logic [7:0]  div_low_r;
    logic [7:0]  div_low_stage_r;
    logic [5:0]  buf_mod_r;
    logic [15:0] bit_period_divider;
    logic [2:0]  fractional_modulation;
    logic        divider_range_select;
    logic [1:0]  receive_trigger_level;

    assign bit_period_divider    = {div_high_r, div_low_r};
    assign fractional_modulation = buf_mod_r[MOD_LSB +: 3];
    assign divider_range_select  = buf_mod_r[RANGE_BIT];
    assign receive_trigger_level = buf_mod_r[TRIG_LSB +: 2];

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            single_wire_select_r <= SINGLE_WIRE_RST[SWM_BIT];
            div_high_r           <= DIV_RST;
            div_low_r            <= DIV_RST;
            div_low_stage_r      <= DIV_RST;
            buf_mod_r            <= BUF_MOD_RST;
        end else if (wr_i) begin
            case (addr_i)
                ADDR_SINGLE_WIRE: single_wire_select_r <= wdata_i[SWM_BIT];
                ADDR_DIV_LOW:     div_low_stage_r <= wdata_i;
                ADDR_DIV_HIGH: begin
                    // low byte staged, both take effect on the high write
                    div_high_r <= wdata_i;
                    div_low_r  <= div_low_stage_r;
                end
                ADDR_BUF_MOD:     buf_mod_r <= wdata_i[5:0];
                default: ;
            endcase
        end
    end

    // =================================================================
    // pin direction and line synchroniser
    logic tx_en;
    logic rx_en;
    logic rx_path;
    logic rx_meta_r;
    logic rx_sync_r;
    logic rx_prev_r;
    logic rx_bit;

    assign tx_en   = port_enable_i && transmitter_enable_i;
    assign rx_en   = port_enable_i && receiver_enable_i;
    assign rx_path = !single_wire_select_r || receiver_enable_i;
    assign rx_bit  = rx_path ? rx_sync_r : 1'b1;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
            rx_prev_r <= 1'b1;
        end else begin
            rx_meta_r <= shared_serial_pin_i;
            rx_sync_r <= rx_meta_r;
            rx_prev_r <= rx_bit;
        end
    end

    // =================================================================
    // receiver
    rx_state_type rx_state_r;
    logic [16:0]  rx_pos;
    logic         rx_end;
    logic         rx_start_det;
    logic [16:0]  half;
    logic [16:0]  sp_a;
    logic [16:0]  sp_b;
    logic [16:0]  sp_c;
    logic [1:0]   rx_smp_r;
    logic         rx_vote_now;
    logic         rx_vote;
    logic [7:0]   rx_shift_r;
    logic [2:0]   rx_bits_r;
    logic         rx_push_r;
    logic [7:0]   rx_byte_r;

    assign rx_start_det = rx_en && (rx_state_r == RX_IDLE) && rx_prev_r && !rx_bit;
    assign half         = {2'b00, bit_period_divider[15:1]};
    assign sp_a         = divider_range_select ? half - 17'h00001 : half;
    assign sp_b         = divider_range_select ? half : half + 17'h00001;
    assign sp_c         = half + 17'h00002;
    assign rx_vote_now  = (rx_state_r != RX_IDLE) && (rx_pos == sp_c);
    assign rx_vote      = majority3({rx_smp_r, rx_bit});

    uart_bit_timer rx_timer (
        .core_clk_i   (core_clk_i),
        .rst_i        (rst_i),
        .run_i        (rx_en && (rx_state_r != RX_IDLE || rx_start_det)),
        .restart_i    (rx_start_det),
        .divider_i    (bit_period_divider),
        .modulation_i (fractional_modulation),
        .pos_o        (rx_pos),
        .bit_end_o    (rx_end)
    );

    always_ff @(posedge core_clk_i) begin
        if (rx_pos == sp_a) begin
            rx_smp_r[1] <= rx_bit;
        end
        if (rx_pos == sp_b) begin
            rx_smp_r[0] <= rx_bit;
        end
    end

    always_ff @(posedge core_clk_i) begin
        rx_push_r <= 1'b0;
        if (rst_i || !rx_en) begin
            rx_state_r <= RX_IDLE;
            rx_bits_r  <= 3'h0;
            rx_shift_r <= 8'h00;
            rx_byte_r  <= 8'h00;
        end else begin
            case (rx_state_r)
                RX_IDLE: begin
                    if (rx_start_det) begin
                        rx_state_r <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_vote_now && rx_vote) begin
                        rx_state_r <= RX_IDLE;
                    end else if (rx_end) begin
                        rx_state_r <= RX_DATA;
                        rx_bits_r  <= 3'h0;
                    end
                end
                RX_DATA: begin
                    if (rx_vote_now) begin
                        rx_shift_r <= {rx_vote, rx_shift_r[7:1]};
                    end
                    if (rx_end) begin
                        rx_bits_r <= rx_bits_r + 3'h1;
                        if (rx_bits_r == LAST_DATA) begin
                            rx_state_r <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_vote_now) begin
                        rx_byte_r  <= rx_shift_r;
                        rx_push_r  <= 1'b1;
                        rx_state_r <= RX_IDLE;
                    end
                end
                default: rx_state_r <= RX_IDLE;
            endcase
        end
    end

    // =================================================================
    // receive buffer, four entries plus the overflow hold register
    logic [7:0] rx_mem [0:3];
    logic [1:0] wr_ptr_r;
    logic [1:0] rd_ptr_r;
    logic [2:0] count_r;
    logic [7:0] hold_r;
    logic       hold_v_r;
    logic       port_en_d_r;
    logic       buf_clear;
    logic       pop;
    logic       mem_we;
    logic [7:0] mem_wd;

    assign buf_clear = rst_i || !port_enable_i || (port_enable_i && !port_en_d_r);
    assign pop       = rd_i && (addr_i == ADDR_DATA) && (count_r != 3'h0);

    always_comb begin
        mem_we = 1'b0;
        mem_wd = rx_byte_r;
        if (pop && hold_v_r) begin
            mem_we = 1'b1;
            mem_wd = hold_r;
        end else if (rx_push_r && (count_r < RX_DEPTH || pop)) begin
            mem_we = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (mem_we && !buf_clear) begin
            rx_mem[wr_ptr_r] <= mem_wd;
        end
    end

    always_ff @(posedge core_clk_i) begin
        port_en_d_r <= rst_i ? 1'b0 : port_enable_i;
        if (buf_clear) begin
            wr_ptr_r <= 2'h0;
            rd_ptr_r <= 2'h0;
            count_r  <= 3'h0;
            hold_v_r <= 1'b0;
            hold_r   <= 8'h00;
        end else begin
            if (mem_we) begin
                wr_ptr_r <= wr_ptr_r + 2'h1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 2'h1;
            end
            if (mem_we && !pop) begin
                count_r <= count_r + 3'h1;
            end else if (pop && !mem_we) begin
                count_r <= count_r - 3'h1;
            end
            if (rx_push_r && count_r == RX_DEPTH && (!pop || hold_v_r)) begin
                hold_r   <= rx_byte_r;
                hold_v_r <= 1'b1;
            end else if (pop && hold_v_r) begin
                hold_v_r <= 1'b0;
            end
        end
    end

    // =================================================================
    // receive-available flag and interrupt request
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            receive_available_flag_o <= 1'b0;
            interrupt_request_o      <= 1'b0;
        end else begin
            receive_available_flag_o <= trigger_met(receive_trigger_level, count_r);
            interrupt_request_o      <= trigger_met(receive_trigger_level, count_r)
                                        && receiver_interrupt_enable_i;
        end
    end

    // =================================================================
    // register read port, data valid only in the cycle after the strobe
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !rd_i) begin
            rdata_o <= 8'h00;
        end else begin
            case (addr_i)
                ADDR_SINGLE_WIRE: rdata_o <= {7'h00, single_wire_select_r};
                ADDR_DATA:        rdata_o <= rx_mem[rd_ptr_r];
                ADDR_DIV_HIGH:    rdata_o <= div_high_r;
                ADDR_DIV_LOW:     rdata_o <= div_low_stage_r;
                ADDR_BUF_MOD:     rdata_o <= {2'b00, buf_mod_r};
                ADDR_UNREAD_CNT:  rdata_o <= {5'h00, count_r};
                default:          rdata_o <= 8'h00;
            endcase
        end
    end

    // =================================================================
    // transmitter
    tx_state_type tx_state_r;
    logic [7:0]   tx_hold_r;
    logic         tx_full_r;
    logic [7:0]   tx_shift_r;
    logic [2:0]   tx_bits_r;
    logic         tx_line_r;
    logic         tx_end;
    logic         tx_load;

    assign tx_load = tx_en && (tx_state_r == TX_IDLE) && tx_full_r;

    uart_bit_timer tx_timer (
        .core_clk_i   (core_clk_i),
        .rst_i        (rst_i),
        .run_i        (tx_en && (tx_state_r != TX_IDLE || tx_load)),
        .restart_i    (tx_load),
        .divider_i    (bit_period_divider),
        .modulation_i (fractional_modulation),
        .pos_o        (),
        .bit_end_o    (tx_end)
    );

    always_ff @(posedge core_clk_i) begin
        if (rst_i || !tx_en) begin
            tx_state_r <= TX_IDLE;
            tx_full_r  <= 1'b0;
            tx_hold_r  <= 8'h00;
            tx_shift_r <= 8'h00;
            tx_bits_r  <= 3'h0;
            tx_line_r  <= 1'b1;
        end else begin
            if (wr_i && addr_i == ADDR_DATA && !tx_full_r) begin
                tx_hold_r <= wdata_i;
                tx_full_r <= 1'b1;
            end
            case (tx_state_r)
                TX_IDLE: begin
                    if (tx_load) begin
                        tx_shift_r <= tx_hold_r;
                        tx_full_r  <= 1'b0;
                        tx_line_r  <= 1'b0;
                        tx_state_r <= TX_START;
                    end
                end
                TX_START: begin
                    if (tx_end) begin
                        tx_line_r  <= tx_shift_r[0];
                        tx_bits_r  <= 3'h0;
                        tx_state_r <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_end) begin
                        tx_bits_r <= tx_bits_r + 3'h1;
                        if (tx_bits_r == LAST_DATA) begin
                            tx_line_r  <= 1'b1;
                            tx_state_r <= TX_STOP;
                        end else begin
                            tx_line_r  <= tx_shift_r[1];
                            tx_shift_r <= {1'b0, tx_shift_r[7:1]};
                        end
                    end
                end
                TX_STOP: begin
                    if (tx_end) begin
                        tx_state_r <= TX_IDLE;
                    end
                end
                default: tx_state_r <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            transmit_pin_o         <= 1'b1;
            transmit_pin_oe_o      <= 1'b0;
            shared_serial_pin_o    <= 1'b1;
            shared_serial_pin_oe_o <= 1'b0;
        end else begin
            transmit_pin_o         <= tx_line_r;
            transmit_pin_oe_o      <= tx_en && !single_wire_select_r;
            shared_serial_pin_o    <= tx_line_r;
            shared_serial_pin_oe_o <= tx_en && single_wire_select_r
                                      && !receiver_enable_i;
        end
    end

    // =================================================================
    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_push_only;
        mem_we && !pop && !buf_clear;
    endsequence
    sequence s_pop_only;
        pop && !mem_we && !buf_clear;
    endsequence

    a_swm_off_rx: assert property (!single_wire_select_r |=> !shared_serial_pin_oe_o)
        else $error("shared pin driven outside single-wire mode");
    a_swm_tx_drive: assert property (single_wire_select_r && tx_en && !receiver_enable_i
        |=> shared_serial_pin_oe_o)
        else $error("shared pin not driven for single-wire transmit");
    a_swm_both_rx: assert property (receiver_enable_i |=> !shared_serial_pin_oe_o)
        else $error("shared pin driven while receiver enabled");
    a_count_inc: assert property (s_push_only |=> count_r == $past(count_r) + 3'h1)
        else $error("unread counter missed an increment");
    a_count_dec: assert property (s_pop_only |=> count_r == $past(count_r) - 3'h1)
        else $error("unread counter missed a decrement");
    a_count_cap: assert property (count_r <= RX_DEPTH)
        else $error("unread counter above four");
    a_overflow_hold: assert property (rx_push_r && count_r == RX_DEPTH && !pop && !buf_clear
        |=> hold_v_r && count_r == RX_DEPTH && hold_r == $past(rx_byte_r))
        else $error("overflow byte not held");
    a_count_clear: assert property (!port_enable_i |=> count_r == 3'h0)
        else $error("unread counter not cleared");
    a_trigger_four: assert property (receive_trigger_level == TRIG_FOUR && count_r == RX_DEPTH
        ##1 receive_trigger_level == TRIG_FOUR |-> receive_available_flag_o)
        else $error("receive-available flag missing at four bytes");
    a_irq_follows: assert property (interrupt_request_o |-> $past(receiver_interrupt_enable_i)
        && receive_available_flag_o)
        else $error("interrupt request without enabled flag");
    a_cnt_read_upper: assert property (rd_i && addr_i == ADDR_UNREAD_CNT
        |=> rdata_o[7:3] == 5'h00 && rdata_o[2:0] == $past(count_r))
        else $error("unread counter read value wrong");
    a_start_vote: assert property (rx_state_r == RX_START && rx_vote_now && rx_vote && rx_en
        |=> rx_state_r == RX_IDLE)
        else $error("false start bit not rejected");
endmodule // uart_single_wire

// file: core/uart_sw_pkg.sv
// =====================================================================
// shared constants for the single-wire serial port
package uart_sw_pkg;
    // register addresses on the plain register port
    localparam logic [2:0] ADDR_SINGLE_WIRE = 3'h0;
    localparam logic [2:0] ADDR_DATA        = 3'h1;
    localparam logic [2:0] ADDR_DIV_HIGH    = 3'h2;
    localparam logic [2:0] ADDR_DIV_LOW     = 3'h3;
    localparam logic [2:0] ADDR_BUF_MOD     = 3'h4;
    localparam logic [2:0] ADDR_UNREAD_CNT  = 3'h5;
    // field positions
    localparam int SWM_BIT   = 0;
    localparam int TRIG_LSB  = 0;
    localparam int RANGE_BIT = 2;
    localparam int MOD_LSB   = 3;
    // reset values
    localparam logic [7:0] SINGLE_WIRE_RST = 8'h00;
    localparam logic [7:0] DIV_RST         = 8'h00;
    localparam logic [5:0] BUF_MOD_RST     = 6'h00;
    // receive buffer and frame
    localparam logic [2:0] RX_DEPTH     = 3'h4;
    localparam logic [2:0] LAST_DATA    = 3'h7;
    localparam logic [1:0] TRIG_FOUR    = 2'h0;
    localparam logic [1:0] TRIG_ONE     = 2'h1;
    localparam logic [1:0] TRIG_TWO     = 2'h2;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_type;

    function automatic logic majority3(input logic [2:0] s);
        majority3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    function automatic logic trigger_met(input logic [1:0] lvl, input logic [2:0] cnt);
        case (lvl)
            TRIG_FOUR: trigger_met = (cnt >= RX_DEPTH);
            TRIG_ONE:  trigger_met = (cnt >= 3'h1);
            TRIG_TWO:  trigger_met = (cnt >= 3'h2);
            default:   trigger_met = (cnt >= 3'h3);
        endcase
    endfunction
endpackage

// file: core/uart_bit_timer.sv
`timescale 1ns/10ps
// =====================================================================
// bit-period timer with fractional modulation accumulator
module uart_bit_timer
    import uart_sw_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        run_i,
    input  wire logic        restart_i,
    input  wire logic [15:0] divider_i,
    input  wire logic [2:0]  modulation_i,
    output logic      [16:0] pos_o,
    output logic             bit_end_o
);
    logic [2:0]  acc_r;
    logic [16:0] pos_r;
    logic [3:0]  sum;
    logic [16:0] limit;

    assign sum       = {1'b0, acc_r} + {1'b0, modulation_i};
    assign limit     = {1'b0, divider_i} + {16'h0000, sum[3]};
    assign bit_end_o = run_i && !restart_i && ((pos_r + 17'h00001) >= limit);
    assign pos_o     = pos_r;

    always_ff @(posedge core_clk_i) begin
        if (rst_i || !run_i || restart_i) begin
            pos_r <= 17'h00000;
            acc_r <= 3'h0;
        end else if (bit_end_o) begin
            pos_r <= 17'h00000;
            acc_r <= sum[2:0];
        end else begin
            pos_r <= pos_r + 17'h00001;
        end
    end
endmodule // uart_bit_timer

// file: tb/uart_remote_model.sv
`timescale 1ns/10ps
// =====================================================================
// remote serial device: sends 8N1 frames and records received ones
module uart_remote_model (
    input  wire logic        core_clk_i,
    input  wire logic [15:0] bit_cycles_i,
    input  wire logic        line_i,
    output logic             line_o
);
    logic [7:0] got_q[$];
    int         low_q[$];

    initial line_o = 1'b1;

    // start, eight data bits lsb first, stop, then one idle bit
    task automatic send_byte(input logic [7:0] b);
        logic [10:0] f;
        f = {2'b11, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge core_clk_i);
            line_o <= f[i];
            repeat (bit_cycles_i - 1) @(posedge core_clk_i);
        end
    endtask

    // short low pulse that must not be taken for a start bit, then a quiet frame time
    task automatic glitch(input int len);
        @(posedge core_clk_i);
        line_o <= 1'b0;
        repeat (len) @(posedge core_clk_i);
        line_o <= 1'b1;
        repeat (11 * bit_cycles_i) @(posedge core_clk_i);
    endtask

    // low run length and mid-bit samples of each received frame
    always begin : watch
        int         n;
        logic [7:0] b;
        @(negedge line_i);
        n = 0;
        b = 8'h00;
        for (int c = 1; c <= 10 * bit_cycles_i; c++) begin
            @(posedge core_clk_i);
            if (line_i === 1'b0 && n == c - 1) n = c;
            if (c % bit_cycles_i == bit_cycles_i / 2 && c > bit_cycles_i && c < 9 * bit_cycles_i)
                b[c / bit_cycles_i - 1] = line_i;
        end
        low_q.push_back(n);
        got_q.push_back(b);
    end
endmodule // uart_remote_model

// file: tb/testbench.sv
`timescale 1ns/10ps
// =====================================================================
// register-level bench for the single-wire serial port
module testbench;
    import uart_sw_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        rst_i      = 1'b1;
    logic [2:0]  addr_i     = 3'h0;
    logic [7:0]  wdata_i    = 8'h00;
    logic        wr_i       = 1'b0;
    logic        rd_i       = 1'b0;
    logic        pen        = 1'b0;
    logic        rxe        = 1'b0;
    logic        txe        = 1'b0;
    logic        rie        = 1'b0;
    logic [15:0] div        = 16'h0014;
    logic [7:0]  rdata_o;
    logic        flag, irq, tx_o, tx_oe, sh_i, sh_o, sh_oe, remote_tx, remote_rx;
    logic [7:0]  d;
    int          mismatches = 0;
    int          comparisons = 0;
    int          cycles = 0;
    logic [7:0]  rx_b [6] = '{8'h3c, 8'ha5, 8'h01, 8'h80, 8'h5a, 8'hff};

    always #25 core_clk_i = ~core_clk_i;
    assign sh_i = sh_oe ? sh_o : remote_tx;
    // released pins float high
    assign remote_rx = tx_oe ? tx_o : (sh_oe ? sh_o : 1'b1);

    uart_single_wire u_dut (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .port_enable_i(pen),
        .receiver_enable_i(rxe), .transmitter_enable_i(txe),
        .receiver_interrupt_enable_i(rie), .receive_available_flag_o(flag),
        .interrupt_request_o(irq), .transmit_pin_o(tx_o), .transmit_pin_oe_o(tx_oe),
        .shared_serial_pin_i(sh_i), .shared_serial_pin_o(sh_o),
        .shared_serial_pin_oe_o(sh_oe));
    uart_remote_model u_remote (.core_clk_i(core_clk_i), .bit_cycles_i(div),
        .line_i(remote_rx), .line_o(remote_tx));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge core_clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        @(posedge core_clk_i);
        v = rdata_o;
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches++;
            close_out();
        end
    end

    initial begin
        repeat (10) @(posedge core_clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 8; a++) if (a != 1) begin
            rd(a[2:0], d);
            chk(d, 8'h00);
        end
        $display("test reset done");
        wr(ADDR_DIV_LOW, 8'h14);
        wr(ADDR_DIV_HIGH, 8'h00);
        wr(ADDR_BUF_MOD, 8'h19);
        rd(ADDR_DIV_LOW, d);
        chk(d, 8'h14);
        pen <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_SINGLE_WIRE, {7'h00, i[2]});
            rxe <= i[1];
            txe <= i[0];
            repeat (3) @(posedge core_clk_i);
            chk({7'h00, sh_oe}, {7'h00, i[2] & i[0] & ~i[1]});
            chk({7'h00, tx_oe}, {7'h00, i[0] & ~i[2]});
        end
        wr(ADDR_SINGLE_WIRE, 8'h00);
        rie <= 1'b1;
        $display("test pins done");
        for (int i = 0; i < 2; i++) u_remote.send_byte(rx_b[i]);
        rd(ADDR_UNREAD_CNT, d);
        chk(d, 8'h02);
        for (int t = 0; t < 4; t++) begin
            wr(ADDR_BUF_MOD, {6'h06, t[1:0]});
            repeat (3) @(posedge core_clk_i);
            chk({7'h00, flag}, {7'h00, t == 1 || t == 2});
            chk({7'h00, irq}, {7'h00, t == 1 || t == 2});
        end
        for (int i = 2; i < 6; i++) u_remote.send_byte(rx_b[i]);
        rd(ADDR_UNREAD_CNT, d);
        chk(d, 8'h04);
        wr(ADDR_BUF_MOD, 8'h18);
        rie <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        chk({6'h00, flag, irq}, 8'h02);
        for (int i = 0; i < 5; i++) begin
            rd(ADDR_DATA, d);
            chk(d, rx_b[i == 4 ? 5 : i]);
            rd(ADDR_UNREAD_CNT, d);
            chk(d, (i == 0) ? 8'h04 : 8'(4 - i));
        end
        u_remote.send_byte(8'h77);
        @(posedge core_clk_i);
        pen <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        pen <= 1'b1;
        rd(ADDR_UNREAD_CNT, d);
        chk(d, 8'h00);
        $display("test receive done");
        div <= 16'h0008;
        wr(ADDR_DIV_LOW, 8'h08);
        wr(ADDR_DIV_HIGH, 8'h00);
        wr(ADDR_BUF_MOD, 8'h05);
        u_remote.send_byte(8'h96);
        rd(ADDR_DATA, d);
        chk(d, 8'h96);
        u_remote.glitch(3);
        rd(ADDR_UNREAD_CNT, d);
        chk(d, 8'h00);
        $display("test short range done");
        div <= 16'h0014;
        wr(ADDR_DIV_LOW, 8'h14);
        wr(ADDR_DIV_HIGH, 8'h00);
        wr(ADDR_BUF_MOD, 8'h19);
        wr(ADDR_DATA, 8'h00);
        repeat (3) @(posedge core_clk_i);
        wr(ADDR_DATA, 8'h00);
        for (int k = 0; k < 1000 && u_remote.got_q.size() < 2; k++) @(posedge core_clk_i);
        wr(ADDR_SINGLE_WIRE, 8'h01);
        rxe <= 1'b0;
        wr(ADDR_DATA, 8'hc3);
        for (int k = 0; k < 1000 && u_remote.got_q.size() < 3; k++) @(posedge core_clk_i);
        chk(8'(u_remote.got_q.size()), 8'h03);
        for (int i = 0; i < 2; i++) chk(u_remote.low_q[i][7:0], 8'hb7);
        chk(u_remote.got_q[2], 8'hc3);
        $display("test transmit done");
        close_out();
    end
endmodule // testbench
